// [hdl/uepb_top.sv]
/*
 three 8-byte endpoint data buffers reached on the processor io bus, filled
 by the usb serial engine through a 16-byte fifo and drained to it directly.
 assumes the engine and the core share mclk; mode and count registers
 live outside, fed by the count and count-load signals here.
*/
// Summary of operation
// - control endpoint buffer: eight read/write bytes at io 0x50 to 0x57.
// - first data endpoint buffer is eight bytes at io 0x58 to 0x5F.
// - second data endpoint buffer is eight bytes at io 0x60 to 0x67.
// - each buffer holds received and transmitted bytes, one shared store.
// - reset leaves buffer bytes untouched; contents undefined after reset.
// - buffers appear only in io space, never in data memory.
// - after out or setup, count becomes received bytes plus two crc.
// - setup-received flag blocks processor writes to control buffer.
`timescale 1ns/1ns
module uepb_top (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   output logic      [7:0] io_rdata,
   output logic            io_hit,
   input  wire logic       setup_received,
   input  wire logic [1:0] sie_ep,
   input  wire logic       sie_rx_start,
   input  wire logic       sie_rx_valid,
   input  wire logic [7:0] sie_rx_data,
   output logic            sie_rx_ready,
   input  wire logic       sie_rx_end,
   input  wire logic       sie_tx_start,
   input  wire logic [3:0] sie_tx_count,
   output logic            sie_tx_valid,
   output logic      [7:0] sie_tx_data,
   input  wire logic       sie_tx_ready,
   output logic      [3:0] rx_byte_count,
   output logic            rx_count_load
);
   import uepb_pkg::*;

   typedef struct packed {
      logic [UEPB_NUM_EP*UEPB_EP_BYTES-1:0][7:0] mem;
      uepb_state_type                            state;
      logic [1:0]                                ep;
      logic [3:0]                                idx;
      logic [3:0]                                len;
      logic                                      rx_done;
      logic [7:0]                                rdata;
      logic                                      hit;
      logic [3:0]                                cnt_out;
      logic                                      cnt_ld;
      logic [7:0]                                tx_data;
      logic                                      tx_vld;
   } uepb_st_type;

   uepb_st_type st_r;
   uepb_st_type st_nxt;
   uepb_fifo_if rx_in ();
   uepb_fifo_if rx_out ();

   // ==========================================================
   // io decode
   function automatic logic io_map(input logic [7:0] a);
      io_map = (a >= UEPB_CTRL_BASE) && (a <= UEPB_DAT2_LAST);
   endfunction

   function automatic logic [UEPB_AW-1:0] io_slot(input logic [7:0] a);
      logic [7:0] off;
      off     = a - UEPB_CTRL_BASE;
      io_slot = off[UEPB_AW-1:0];
   endfunction

   function automatic logic [UEPB_AW-1:0] ep_slot(input logic [1:0] e,
                                                  input logic [3:0] i);
      ep_slot = {e, i[UEPB_EP_AW-1:0]};
   endfunction

   // ==========================================================
   // rx fifo between engine and buffers
   assign rx_in.valid  = sie_rx_valid;
   assign rx_in.data   = sie_rx_data;
   assign sie_rx_ready = rx_in.ready;
   // bytes beyond eight are dropped; stalling there would hang the engine
   assign rx_out.ready = (st_r.state == UEPB_RECV);

   uepb_fifo #(
      .W  (UEPB_FIFO_W),
      .D  (UEPB_FIFO_D),
      .PW (UEPB_FIFO_PW)
   ) u_rx_fifo (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .wr      (rx_in),
      .rd      (rx_out)
   );

   logic io_wr_ok;
   logic rx_take;
   logic tx_take;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.cnt_ld = 1'b0;
      rx_take       = rx_out.valid && rx_out.ready;
      tx_take       = st_r.tx_vld && sie_tx_ready;
      io_wr_ok      = io_wr && io_map(io_addr)
                      && !(setup_received
                           && io_addr <= UEPB_CTRL_LAST);
      // processor write first so the engine store below overrides it
      if (io_wr_ok) begin
         st_nxt.mem[io_slot(io_addr)] = io_wdata;
      end
      st_nxt.hit = io_rd && io_map(io_addr);
      if (io_rd && io_map(io_addr)) begin
         st_nxt.rdata = st_r.mem[io_slot(io_addr)];
      end
      unique case (st_r.state)
         UEPB_IDLE: begin
            st_nxt.idx = '0;
            if (sie_rx_start) begin
               st_nxt.state   = UEPB_RECV;
               st_nxt.ep      = sie_ep;
               st_nxt.rx_done = 1'b0;
            end else if (sie_tx_start) begin
               st_nxt.state = UEPB_SEND;
               st_nxt.ep    = sie_ep;
               st_nxt.len   = (sie_tx_count > UEPB_TX_MAX) ?
                              UEPB_TX_MAX : sie_tx_count;
            end
         end
         UEPB_RECV: begin
            if (rx_take) begin
               if (st_r.idx < UEPB_TX_MAX) begin
                  // same buffer serves reception
                  st_nxt.mem[ep_slot(st_r.ep, st_r.idx)] = rx_out.data;
               end
               st_nxt.idx = st_r.idx + 4'h1;
            end
            if (sie_rx_end) begin
               st_nxt.rx_done = 1'b1;
            end
            if ((st_r.rx_done || sie_rx_end) && !rx_out.valid) begin
               st_nxt.state   = UEPB_IDLE;
               st_nxt.cnt_out = st_r.idx + UEPB_CRC_BYTES;
               st_nxt.cnt_ld  = 1'b1;
            end
         end
         UEPB_SEND: begin
            // and the same buffer is drained for transmission
            if (!st_r.tx_vld || tx_take) begin
               if (st_r.idx < st_r.len) begin
                  st_nxt.tx_data = st_r.mem[ep_slot(st_r.ep, st_r.idx)];
                  st_nxt.tx_vld  = 1'b1;
                  st_nxt.idx     = st_r.idx + 4'h1;
               end else begin
                  st_nxt.tx_vld = 1'b0;
                  st_nxt.state  = UEPB_IDLE;
               end
            end
         end
         default: st_nxt.state = UEPB_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // buffer bytes deliberately left alone
         st_r.state   <= UEPB_IDLE;
         st_r.ep      <= '0;
         st_r.idx     <= '0;
         st_r.len     <= '0;
         st_r.rx_done <= 1'b0;
         st_r.rdata   <= '0;
         st_r.hit     <= 1'b0;
         st_r.cnt_out <= '0;
         st_r.cnt_ld  <= 1'b0;
         st_r.tx_data <= '0;
         st_r.tx_vld  <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign io_rdata      = st_r.rdata;
   assign io_hit        = st_r.hit;
   assign sie_tx_valid  = st_r.tx_vld;
   assign sie_tx_data   = st_r.tx_data;
   assign rx_byte_count = st_r.cnt_out;
   assign rx_count_load = st_r.cnt_ld;

   // ==========================================================
   // checks
   sequence s_ctrl_wr_locked;
      io_wr && setup_received && io_addr >= UEPB_CTRL_BASE
      && io_addr <= UEPB_CTRL_LAST;
   endsequence

   AST_CTRL_LOCK: assert property (@(posedge mclk)
      disable iff (sys_rst)
      (s_ctrl_wr_locked
       and (clk_en && !(st_r.state == UEPB_RECV && rx_take)))
      |=> st_r.mem[io_slot($past(io_addr))]
          == $past(st_r.mem[io_slot(io_addr)]))
      else $error("locked control buffer was written");
   AST_RD_DATA: assert property (@(posedge mclk)
      disable iff (sys_rst)
      io_rd && io_map(io_addr) && clk_en && !io_wr_ok && !rx_take
      |=> io_hit && io_rdata == st_r.mem[io_slot($past(io_addr))])
      else $error("read data mismatch");
   AST_UNMAPPED: assert property (@(posedge mclk)
      disable iff (sys_rst)
      clk_en && io_rd
      && (io_addr < UEPB_CTRL_BASE || io_addr > UEPB_DAT2_LAST)
      |=> !io_hit)
      else $error("unmapped address answered");
   AST_WR_STORE: assert property (@(posedge mclk)
      disable iff (sys_rst)
      clk_en && io_wr_ok && !rx_take
      |=> st_r.mem[io_slot($past(io_addr))] == $past(io_wdata))
      else $error("io write not stored");
   AST_RX_WINS: assert property (@(posedge mclk)
      disable iff (sys_rst)
      clk_en && rx_take && st_r.idx < UEPB_TX_MAX
      |=> st_r.mem[ep_slot($past(st_r.ep), $past(st_r.idx))]
          == $past(rx_out.data))
      else $error("received byte lost");
   AST_COUNT: assert property (@(posedge mclk)
      disable iff (sys_rst)
      rx_count_load |-> rx_byte_count >= UEPB_CRC_BYTES)
      else $error("byte count below crc size");
   AST_TX_LEN: assert property (@(posedge mclk)
      disable iff (sys_rst)
      st_r.state == UEPB_SEND |-> st_r.len <= UEPB_TX_MAX)
      else $error("transmit length above eight");
   AST_TX_HOLD: assert property (@(posedge mclk)
      disable iff (sys_rst)
      sie_tx_valid && !sie_tx_ready && clk_en
      |=> sie_tx_valid && $stable(sie_tx_data))
      else $error("tx byte dropped under stall");
   AST_RST_IDLE: assert property (@(posedge mclk)
      sys_rst |=> !sie_tx_valid && !io_hit && !rx_count_load)
      else $error("outputs not idle after reset");
endmodule

// [hdl/uepb_pkg.sv]
/*
 package of the endpoint data buffer block: io map, count encodings and
 fifo sizing. assumes an 8-bit io bus of the processor core.
*/
package uepb_pkg;
   // ==========================================================
   // io map
   localparam logic [7:0] UEPB_CTRL_BASE  = 8'h50;
   localparam logic [7:0] UEPB_CTRL_LAST  = 8'h57;
   localparam logic [7:0] UEPB_DAT1_BASE  = 8'h58;
   localparam logic [7:0] UEPB_DAT1_LAST  = 8'h5F;
   localparam logic [7:0] UEPB_DAT2_BASE  = 8'h60;
   localparam logic [7:0] UEPB_DAT2_LAST  = 8'h67;
   localparam int         UEPB_NUM_EP     = 3;
   localparam int         UEPB_EP_BYTES   = 8;
   localparam int         UEPB_EP_AW      = 3;
   localparam int         UEPB_AW         = 5;
   // ==========================================================
   // byte counts
   localparam logic [3:0] UEPB_CRC_BYTES  = 4'h2;
   localparam logic [3:0] UEPB_TX_MAX     = 4'h8;
   // ==========================================================
   // fifo
   localparam int         UEPB_FIFO_W     = 8;
   localparam int         UEPB_FIFO_D     = 16;
   localparam int         UEPB_FIFO_PW    = 4;
   localparam logic [4:0] UEPB_FIFO_ONE   = 5'h01;
   localparam logic [3:0] UEPB_PTR_ONE    = 4'h1;

   typedef enum logic [1:0] {
      UEPB_IDLE = 2'b00,
      UEPB_RECV = 2'b01,
      UEPB_SEND = 2'b10
   } uepb_state_type;
endpackage

// [hdl/uepb_fifo_if.sv]
/*
 valid/ready byte stream between the engine front end and the buffer
 core. assumes one clock for both ends.
*/
`timescale 1ns/1ns
interface uepb_fifo_if;
   logic                          valid;
   logic                          ready;
   logic [uepb_pkg::UEPB_FIFO_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [hdl/uepb_fifo.sv]
/*
 small synchronous fifo of flip-flops, width and depth as parameters.
 assumes a single clock, synchronous reset and a clock enable.
*/
`timescale 1ns/1ns
module uepb_fifo #(
   parameter int W  = 8,
   parameter int D  = 16,
   parameter int PW = 4
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   uepb_fifo_if.snk  wr,
   uepb_fifo_if.src  rd
);
   import uepb_pkg::*;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0]       wp;
      logic [PW-1:0]       rp;
      logic [PW:0]         cnt;
   } uepb_fifo_st_type;

   uepb_fifo_st_type st_r;
   uepb_fifo_st_type st_nxt;
   logic             push;
   logic             pop;

   // full at exactly D entries; the count is one bit wider than a pointer
   assign wr.ready = (st_r.cnt != (PW+1)'(D));
   assign rd.valid = (st_r.cnt != '0);
   assign rd.data  = st_r.mem[st_r.rp];
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = wr.data;
         st_nxt.wp           = st_r.wp + UEPB_PTR_ONE;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + UEPB_PTR_ONE;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + UEPB_FIFO_ONE;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - UEPB_FIFO_ONE;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r.wp  <= '0;
         st_r.rp  <= '0;
         st_r.cnt <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   AST_FIFO_NO_OVERFLOW: assert property (@(posedge mclk)
      disable iff (sys_rst) st_r.cnt <= (PW+1)'(D))
      else $error("fifo count beyond depth");
endmodule

// [sim/uepb_sie_model.sv]
/*
 behavioural model of the usb serial engine beside the endpoint buffers.
 assumes the shared mclk; the bench calls its tasks by hierarchy.
*/
`timescale 1ns/1ns
module uepb_sie_model (
   input  wire logic       mclk,
   output logic      [1:0] sie_ep,
   output logic            sie_rx_start,
   output logic            sie_rx_valid,
   output logic      [7:0] sie_rx_data,
   input  wire logic       sie_rx_ready,
   output logic            sie_rx_end,
   output logic            sie_tx_start,
   output logic      [3:0] sie_tx_count,
   input  wire logic       sie_tx_valid,
   input  wire logic [7:0] sie_tx_data,
   output logic            sie_tx_ready
);
   logic [7:0] txq[$];
   logic       slow;

   initial begin
      sie_ep       = 2'h0;
      sie_rx_start = 1'b0;
      sie_rx_valid = 1'b0;
      sie_rx_data  = 8'h00;
      sie_rx_end   = 1'b0;
      sie_tx_start = 1'b0;
      sie_tx_count = 4'h0;
      sie_tx_ready = 1'b0;
      slow         = 1'b0;
   end

   // ==========================================================
   // receive: start, bytes held until taken, end
   task automatic rx_pkt(input logic [1:0] ep, input int n);
      @(posedge mclk);
      sie_ep       <= ep;
      sie_rx_start <= 1'b1;
      @(posedge mclk);
      sie_rx_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         sie_rx_valid <= 1'b1;
         sie_rx_data  <= 8'(8'hC0 + 8 * ep + i);
         @(negedge mclk);
         while (!sie_rx_ready) @(negedge mclk);
         @(posedge mclk);
      end
      sie_rx_valid <= 1'b0;
      // released data shows garbage, not the last byte
      sie_rx_data  <= ~sie_rx_data;
      sie_rx_end   <= 1'b1;
      @(posedge mclk);
      sie_rx_end   <= 1'b0;
   endtask

   // ==========================================================
   // transmit: count loaded in the same cycle as start; slow stalls every other cycle
   task automatic tx_go(input logic [1:0] ep, input logic [3:0] cnt,
                        input logic s);
      txq.delete();
      slow <= s;
      @(posedge mclk);
      sie_ep       <= ep;
      sie_tx_count <= cnt;
      sie_tx_start <= 1'b1;
      @(posedge mclk);
      sie_tx_start <= 1'b0;
   endtask

   always @(posedge mclk) begin
      sie_tx_ready <= slow ? ~sie_tx_ready : 1'b1;
      if (sie_tx_valid && sie_tx_ready)
         txq.push_back(sie_tx_data);
   end
endmodule

// [sim/tb.sv]
/*
 self-checking bench of the endpoint buffers: io bus tasks, engine model.
 assumes one clock of 8 ns; buffer bytes are never read before written.
*/
`timescale 1ns/1ns
module tb;
   import uepb_pkg::*;
   logic       mclk, sys_rst, clk_en, io_wr, io_rd, io_hit;
   logic [7:0] io_addr, io_wdata, io_rdata, sie_rx_data, sie_tx_data;
   logic       setup_received, sie_rx_start, sie_rx_valid, sie_rx_ready;
   logic       sie_rx_end, sie_tx_start, sie_tx_valid, sie_tx_ready;
   logic [1:0] sie_ep;
   logic [3:0] sie_tx_count, rx_byte_count;
   logic       rx_count_load;
   int         n_errors, compares, cyc;

   uepb_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
      .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
      .setup_received(setup_received), .sie_ep(sie_ep),
      .sie_rx_start(sie_rx_start), .sie_rx_valid(sie_rx_valid),
      .sie_rx_data(sie_rx_data), .sie_rx_ready(sie_rx_ready),
      .sie_rx_end(sie_rx_end), .sie_tx_start(sie_tx_start),
      .sie_tx_count(sie_tx_count), .sie_tx_valid(sie_tx_valid),
      .sie_tx_data(sie_tx_data), .sie_tx_ready(sie_tx_ready),
      .rx_byte_count(rx_byte_count), .rx_count_load(rx_count_load));

   uepb_sie_model i_sie (.mclk(mclk), .sie_ep(sie_ep),
      .sie_rx_start(sie_rx_start), .sie_rx_valid(sie_rx_valid),
      .sie_rx_data(sie_rx_data), .sie_rx_ready(sie_rx_ready),
      .sie_rx_end(sie_rx_end), .sie_tx_start(sie_tx_start),
      .sie_tx_count(sie_tx_count), .sie_tx_valid(sie_tx_valid),
      .sie_tx_data(sie_tx_data), .sie_tx_ready(sie_tx_ready));

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic io_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge mclk);
      io_wr    <= 1'b0;
   endtask

   task automatic io_r(input logic [7:0] a, input logic [7:0] exp,
                       input logic hit);
      @(posedge mclk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge mclk);
      io_rd   <= 1'b0;
      @(negedge mclk);
      chk({7'h0, io_hit}, {7'h0, hit});
      if (hit)
         chk(io_rdata, exp);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_io();
      for (int a = 8'h50; a <= 8'h67; a++)
         io_w(8'(a), ~8'(a));
      for (int a = 8'h50; a <= 8'h67; a++)
         io_r(8'(a), ~8'(a), 1'b1);
      io_r(8'h4F, 8'h00, 1'b0);
      io_r(8'h68, 8'h00, 1'b0);
      // clock enable low freezes state: this write must not land
      clk_en <= 1'b0;
      io_w(8'h51, 8'h5A);
      clk_en <= 1'b1;
      io_r(8'h51, 8'hAE, 1'b1);
   endtask

   task automatic t_tx(input logic [1:0] ep, input logic [3:0] cnt,
                       input int n, input logic s);
      i_sie.tx_go(ep, cnt, s);
      for (int k = 0; k < 60 && i_sie.txq.size() < n; k++) @(posedge mclk);
      // let any surplus byte show before counting
      repeat (20) @(posedge mclk);
      chk(8'(i_sie.txq.size()), 8'(n));
      for (int i = 0; i < n && i < i_sie.txq.size(); i++)
         chk(i_sie.txq[i], ~8'(8'h50 + 8 * ep + i));
   endtask

   task automatic t_lock();
      setup_received <= 1'b1;
      io_w(8'h50, 8'h11);
      io_w(8'h58, 8'h22);
      setup_received <= 1'b0;
      io_r(8'h50, 8'hAF, 1'b1);
      io_r(8'h58, 8'h22, 1'b1);
   endtask

   task automatic t_rx(input logic [1:0] ep, input int n);
      int k;
      i_sie.rx_pkt(ep, n);
      k = 0;
      while (rx_count_load !== 1'b1 && k < 40) begin
         @(negedge mclk);
         k++;
      end
      chk({7'h0, rx_count_load}, 8'h01);
      chk({4'h0, rx_byte_count}, 8'(n + 2));
      for (int i = 0; i < n; i++)
         io_r(8'(8'h50 + 8 * ep + i), 8'(8'hC0 + 8 * ep + i), 1'b1);
   endtask

   // ==========================================================
   // clock, watchdog, main sequence
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      n_errors       = 0;
      compares       = 0;
      cyc            = 0;
      sys_rst        = 1'b1;
      clk_en         = 1'b1;
      io_addr        = 8'h00;
      io_wdata       = 8'h00;
      io_wr          = 1'b0;
      io_rd          = 1'b0;
      setup_received = 1'b0;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      t_io();
      t_tx(2'h2, 4'h9, 8, 1'b1);
      t_tx(2'h1, 4'h0, 0, 1'b0);
      t_tx(2'h0, 4'h3, 3, 1'b0);
      t_lock();
      t_rx(2'h0, 8);
      t_rx(2'h1, 3);
      t_rx(2'h2, 0);
      results();
   end
endmodule
